// ---- rtl/monitor_mode_debug_control.sv ----
/*
 * Monitor-mode debug control: programmable comparators, debug control register,
 * abort status register, target/host communication channel, and a compact
 * serial scan port for the external debugger.
 * Assumes tck/tms/tdi are asynchronous pins and the core reads and writes the
 * debug coprocessor synchronously on clk_sys_in.
 */
`timescale 1ns/1ps
`include "dbg_defs.svh"

// Notes on behaviour
// RULE1: software programs address and kind for each comparator that fires a breakpoint or watchpoint.
// RULE2: with the monitor bit set a hit raises an instruction or data abort, otherwise it halts the core.
// RULE3: with the comparator-disable bit set no hit is reported, and clearing it makes new values live.
// RULE4: in monitor mode the interrupt lines pass to the core untouched; only a halt masks them.
// RULE5: the abort status register tells whether the last abort came from a real fault or a debug hit.
// RULE6: a receive and a transmit word with full flags carry data between target and host debugger.
// RULE7: the host drives control, comparators and the channel through the serial test access port.
module monitor_mode_debug_control #(
	parameter int NUM_CMP = 2
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	input wire dbg_pkg::core_access_s access_in,
	input wire logic mem_abort_in,
	input wire logic irq_in,
	input wire logic fiq_in,
	output logic irq_out,
	output logic fiq_out,
	output dbg_pkg::debug_event_s event_out,
	input wire logic cp_wr_in,
	input wire logic cp_rd_in,
	input wire logic [3:0] cp_reg_in,
	input wire logic [31:0] cp_wdata_in,
	output logic [31:0] cp_rdata_out,
	input wire logic resume_in
);
	import dbg_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pin_meta_q, pin_sync_q;
	logic tck_prev_q;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
			tck_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= {tck_in, tms_in, tdi_in};
			pin_sync_q <= pin_meta_q;
			tck_prev_q <= pin_sync_q[2];
		end
	end
	logic tck_rise;
	assign tck_rise = pin_sync_q[2] & ~tck_prev_q;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [`CTRL_WIDTH-1:0] ctrl_q, ctrl_d;
	logic [31:0] cmp_addr_q [NUM_CMP], cmp_addr_d [NUM_CMP];
	logic [NUM_CMP-1:0] cmp_data_q, cmp_data_d;
	logic [NUM_CMP-1:0] cmp_en_q, cmp_en_d;
	logic [31:0] rx_q, rx_d, tx_q, tx_d;
	logic rx_full_q, rx_full_d, tx_full_q, tx_full_d;
	logic abort_dbg_q, abort_dbg_d;
	logic halted_q, halted_d;
	debug_event_s event_q, event_d;
	tap_state_e tap_q, tap_d;
	logic [`SCAN_WORD_LEN-1:0] shift_q, shift_d;
	logic [31:0] rdata_q, rdata_d;

	// ----------------------------------------------------------------
	// comparators
	// ----------------------------------------------------------------
	logic [NUM_CMP-1:0] hit;
	genvar g;
	generate
		for (g = 0; g < NUM_CMP; g++) begin : g_cmp
			// a comparator fires only on matching address and access kind [RULE1]
			assign hit[g] = cmp_en_q[g] & access_in.valid & (access_in.addr == cmp_addr_q[g])
				& (access_in.instr != cmp_data_q[g]);
		end
	endgenerate

	logic any_hit;
	// disable bit gates every comparator while they are rewritten [RULE3]
	assign any_hit = (|hit) & ~ctrl_q[`CTRL_BIT_CMP_OFF];

	// only a halt stops interrupts; monitor mode keeps them flowing [RULE4]
	assign irq_out = irq_in & ~halted_q;
	assign fiq_out = fiq_in & ~halted_q;
	assign event_out = event_q;
	assign cp_rdata_out = rdata_q;
	assign tdo_out = shift_q[0];

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	logic [3:0] scan_addr;
	logic scan_wr;
	logic [31:0] scan_data;
	int idx;
	always_comb begin
		ctrl_d = ctrl_q;
		cmp_addr_d = cmp_addr_q;
		cmp_data_d = cmp_data_q;
		cmp_en_d = cmp_en_q;
		rx_d = rx_q;
		tx_d = tx_q;
		rx_full_d = rx_full_q;
		tx_full_d = tx_full_q;
		abort_dbg_d = abort_dbg_q;
		halted_d = halted_q;
		event_d = '0;
		tap_d = tap_q;
		shift_d = shift_q;
		rdata_d = rdata_q;
		scan_addr = shift_q[36:33];
		scan_wr = shift_q[32];
		scan_data = shift_q[31:0];
		idx = 0;

		// hit handling: monitor bit picks abort versus halt [RULE2]
		if (any_hit && !halted_q) begin
			if (ctrl_q[`CTRL_BIT_MONITOR]) begin
				event_d.abort_instr = access_in.instr;
				event_d.abort_data = ~access_in.instr;
			end else begin
				event_d.halt = 1'b1;
				halted_d = 1'b1;
			end
		end
		if (resume_in)
			halted_d = 1'b0;

		// record the cause of each abort; debug hit wins a tie [RULE5]
		if (mem_abort_in)
			abort_dbg_d = 1'b0;
		if (any_hit && !halted_q && ctrl_q[`CTRL_BIT_MONITOR])
			abort_dbg_d = 1'b1;

		// core side of the channel [RULE6]
		if (cp_rd_in) begin
			case (cp_reg_in)
				`CP_REG_RX: begin
					rdata_d = rx_q;
					rx_full_d = 1'b0;
				end
				`CP_REG_TX: rdata_d = {30'h0, tx_full_q, rx_full_q};
				`CP_REG_ABORT: rdata_d = {31'h0, abort_dbg_q};
				default: rdata_d = 32'h0;
			endcase
		end
		if (cp_wr_in && cp_reg_in == `CP_REG_TX) begin
			tx_d = cp_wdata_in;
			tx_full_d = 1'b1;
		end

		// serial port: tms high shifts, tms low after a shift updates [RULE7]
		if (tck_rise) begin
			case (tap_q)
				TAP_IDLE: begin
					if (pin_sync_q[1])
						tap_d = TAP_SHIFT;
				end
				TAP_SHIFT: begin
					shift_d = {pin_sync_q[0], shift_q[`SCAN_WORD_LEN-1:1]};
					if (!pin_sync_q[1])
						tap_d = TAP_UPDATE;
				end
				TAP_UPDATE: begin
					tap_d = TAP_IDLE;
					if (scan_wr) begin
						if (scan_addr == `SCAN_ADDR_CTRL)
							ctrl_d = scan_data[`CTRL_WIDTH-1:0];
						else if (scan_addr == `SCAN_ADDR_COMM_DATA) begin
							rx_d = scan_data;
							rx_full_d = 1'b1;
						end else if (scan_addr >= `SCAN_ADDR_CMP_BASE) begin
							// two codes per comparator: even watches instructions, odd watches data [RULE1]
							idx = int'((scan_addr - `SCAN_ADDR_CMP_BASE) >> 1);
							if (idx < NUM_CMP) begin
								cmp_addr_d[idx] = scan_data;
								cmp_data_d[idx] = scan_addr[0];
								cmp_en_d[idx] = 1'b1;
							end
						end
					end else begin
						case (scan_addr)
							`SCAN_ADDR_CTRL: shift_d = {5'h0, 26'h0, ctrl_q};
							`SCAN_ADDR_STATUS: shift_d = {5'h0, 30'h0, halted_q, abort_dbg_q};
							`SCAN_ADDR_COMM_CTRL: shift_d = {5'h0, 30'h0, tx_full_q, rx_full_q};
							`SCAN_ADDR_COMM_DATA: begin
								shift_d = {5'h0, tx_q};
								tx_full_d = 1'b0;
							end
							default: shift_d = '0;
						endcase
					end
				end
				default: tap_d = TAP_IDLE;
			endcase
		end
		// a core write in the same cycle as a host drain keeps the word [RULE6]
		if (cp_wr_in && cp_reg_in == `CP_REG_TX)
			tx_full_d = 1'b1;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q <= `CTRL_RESET;
			for (int i = 0; i < NUM_CMP; i++)
				cmp_addr_q[i] <= 32'h0;
			cmp_data_q <= '0;
			cmp_en_q <= '0;
			rx_q <= 32'h0;
			tx_q <= 32'h0;
			rx_full_q <= 1'b0;
			tx_full_q <= 1'b0;
			abort_dbg_q <= 1'b0;
			halted_q <= 1'b0;
			event_q <= '0;
			tap_q <= TAP_IDLE;
			shift_q <= '0;
			rdata_q <= 32'h0;
		end else begin
			ctrl_q <= ctrl_d;
			cmp_addr_q <= cmp_addr_d;
			cmp_data_q <= cmp_data_d;
			cmp_en_q <= cmp_en_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			rx_full_q <= rx_full_d;
			tx_full_q <= tx_full_d;
			abort_dbg_q <= abort_dbg_d;
			halted_q <= halted_d;
			event_q <= event_d;
			tap_q <= tap_d;
			shift_q <= shift_d;
			rdata_q <= rdata_d;
		end
	end
endmodule : monitor_mode_debug_control

// ---- rtl/dbg_defs.svh ----
/*
 * Constants for the monitor-mode debug control block: register field
 * positions, reset values and scan command codes.
 * Assumes it is included by bare name from the design file.
 */
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH

// ----------------------------------------------------------------
// debug control register fields
// ----------------------------------------------------------------
`define CTRL_WIDTH 6
`define CTRL_RESET 6'h00
`define CTRL_BIT_MONITOR 4
`define CTRL_BIT_CMP_OFF 5

// ----------------------------------------------------------------
// debug coprocessor register numbers
// ----------------------------------------------------------------
`define CP_REG_RX 4'h0
`define CP_REG_TX 4'h1
`define CP_REG_ABORT 4'h2

// ----------------------------------------------------------------
// scan command codes (4-bit address field of the scan word)
// ----------------------------------------------------------------
`define SCAN_ADDR_CTRL 4'h0
`define SCAN_ADDR_STATUS 4'h1
`define SCAN_ADDR_COMM_CTRL 4'h4
`define SCAN_ADDR_COMM_DATA 4'h5
`define SCAN_ADDR_CMP_BASE 4'h8
`define SCAN_WORD_LEN 37

`endif

// ---- rtl/dbg_pkg.sv ----
/*
 * Types shared by the monitor-mode debug control block.
 * Assumes the matching _defs header supplies the numeric constants.
 */
package dbg_pkg;
	typedef struct packed {
		logic [31:0] addr;
		logic instr;
		logic valid;
	} core_access_s;

	typedef struct packed {
		logic abort_instr;
		logic abort_data;
		logic halt;
	} debug_event_s;

	typedef enum logic [1:0] {
		TAP_IDLE = 2'b00,
		TAP_SHIFT = 2'b01,
		TAP_UPDATE = 2'b10
	} tap_state_e;
endpackage : dbg_pkg

// ---- testbench/dbg_ctl_asserts.sv ----
/* port-level checker for the debug control block.
   assumes it is bound to monitor_mode_debug_control. */
`timescale 1ns/1ps
module dbg_ctl_asserts (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire dbg_pkg::core_access_s access_in,
	input wire logic mem_abort_in,
	input wire logic irq_in,
	input wire logic irq_out,
	input wire logic fiq_in,
	input wire logic fiq_out,
	input wire dbg_pkg::debug_event_s event_out,
	input wire logic cp_rd_in,
	input wire logic [3:0] cp_reg_in,
	input wire logic [31:0] cp_rdata_out,
	input wire logic resume_in
);
	import dbg_pkg::*;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	AST_IRQ_GATE: assert property (irq_out |-> irq_in) else $error("irq out without request");
	AST_FIQ_GATE: assert property (fiq_out |-> fiq_in) else $error("fiq out without request");
	AST_HALT_MASK: assert property (event_out.halt && !resume_in |=> !irq_out && !fiq_out) else $error("irq in halt");
	AST_HIT_SRC: assert property (event_out != 3'h0 |-> $past(access_in.valid)) else $error("event without access");
	AST_ONE_EVT: assert property ($onehot0(event_out)) else $error("two events at once");
	AST_KIND: assert property (event_out.abort_instr |-> $past(access_in.instr)) else $error("wrong abort kind");
	AST_KIND_DATA: assert property (event_out.abort_data |-> !$past(access_in.instr)) else $error("wrong data abort");
	AST_HALT_ONCE: assert property (event_out.halt |=> !event_out.halt) else $error("hit while halted");
	AST_RD_HOLD: assert property (!cp_rd_in |=> $stable(cp_rdata_out)) else $error("read data moved");
	AST_RD_NONE: assert property (cp_rd_in && cp_reg_in > 4'h2 |=> cp_rdata_out == 32'h0) else $error("unmapped read");
	AST_ABT_DBG: assert property (event_out.abort_instr ##1 (cp_rd_in && cp_reg_in == 4'h2 && !mem_abort_in)
		|=> cp_rdata_out[0]) else $error("abort cause lost");
	cover property (event_out.abort_instr);
	cover property (event_out.halt);
	cover property (event_out.abort_data);
	cover property (cp_rd_in && cp_reg_in == 4'h2);
endmodule : dbg_ctl_asserts

bind monitor_mode_debug_control dbg_ctl_asserts u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.access_in(access_in), .mem_abort_in(mem_abort_in), .irq_in(irq_in), .irq_out(irq_out), .fiq_in(fiq_in),
	.fiq_out(fiq_out), .event_out(event_out), .cp_rd_in(cp_rd_in), .cp_reg_in(cp_reg_in),
	.cp_rdata_out(cp_rdata_out), .resume_in(resume_in));

// ---- testbench/dbg_host_model.sv ----
/* host debugger model: drives the serial scan pins.
   assumes tck half period of 5 system clocks covers the pin synchronisers. */
`timescale 1ns/1ps
module dbg_host_model (
	input wire logic clk_in,
	input wire logic tdo_in,
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out
);
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b0;
		tdi_out = 1'b0;
	end
	task automatic tick(input logic m, input logic d);
		tms_out = m;
		tdi_out = d;
		repeat (5) @(negedge clk_in);
		tck_out = 1'b1;
		repeat (5) @(negedge clk_in);
		tck_out = 1'b0;
	endtask : tick
	// tck stands low between frames; tdi shows the inverse so stale bits never pass
	task automatic scan(input logic [36:0] w, output logic [36:0] r);
		tick(1'b1, ~tdi_out);
		for (int i = 0; i < 37; i++) begin
			r[i] = tdo_in;
			tick(i != 36, w[i]);
		end
		tick(1'b0, ~w[36]);
	endtask : scan
endmodule : dbg_host_model

// ---- testbench/monitor_mode_debug_control_tb.sv ----
/* self-checking bench for the debug control block.
   assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module monitor_mode_debug_control_tb;
	import dbg_pkg::*;
	logic clk_sys_in, rst_in, tck_in, tms_in, tdi_in, tdo_out, mem_abort_in, irq_in, fiq_in, irq_out, fiq_out;
	logic cp_wr_in, cp_rd_in, resume_in;
	logic [3:0] cp_reg_in;
	logic [31:0] cp_wdata_in, cp_rdata_out;
	logic [36:0] r;
	core_access_s access_in;
	debug_event_s event_out;
	int miscompares = 0;
	int total_checks = 0;
	monitor_mode_debug_control dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tck_in(tck_in), .tms_in(tms_in),
		.tdi_in(tdi_in), .tdo_out(tdo_out), .access_in(access_in), .mem_abort_in(mem_abort_in), .irq_in(irq_in),
		.fiq_in(fiq_in), .irq_out(irq_out), .fiq_out(fiq_out), .event_out(event_out), .cp_wr_in(cp_wr_in),
		.cp_rd_in(cp_rd_in), .cp_reg_in(cp_reg_in), .cp_wdata_in(cp_wdata_in), .cp_rdata_out(cp_rdata_out),
		.resume_in(resume_in));
	dbg_host_model host (.clk_in(clk_sys_in), .tdo_in(tdo_out), .tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic acc(input logic [31:0] a, input logic k = 1'b1);
		@(negedge clk_sys_in) access_in = '{a, k, 1'b1};
		@(negedge clk_sys_in) access_in.valid = 1'b0;
	endtask : acc
	task automatic cp(input logic w, input logic [3:0] rg, input logic [31:0] wd);
		@(negedge clk_sys_in) {cp_wr_in, cp_rd_in, cp_reg_in, cp_wdata_in} = {w, !w, rg, wd};
		@(negedge clk_sys_in) {cp_wr_in, cp_rd_in} = 2'b00;
	endtask : cp
	task automatic sw(input logic [3:0] a, input logic [31:0] v);
		host.scan({a, 1'b1, v}, r);
	endtask : sw
	// a read result only leaves on the following scan, so a status read fetches it
	task automatic srd(input logic [3:0] a);
		host.scan({a, 1'b0, 32'h0}, r);
		host.scan({4'h1, 1'b0, 32'h0}, r);
	endtask : srd
	task automatic pulse_resume();
		@(negedge clk_sys_in) resume_in = 1'b1;
		@(negedge clk_sys_in) resume_in = 1'b0;
	endtask : pulse_resume
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		miscompares++;
		conclude();
	end
	initial begin
		{rst_in, mem_abort_in, irq_in, fiq_in, cp_wr_in, cp_rd_in, resume_in} = 7'b1011000;
		{cp_reg_in, cp_wdata_in} = 36'h0;
		access_in = '{32'h0, 1'b0, 1'b0};
		repeat (12) @(posedge clk_sys_in);
		@(negedge clk_sys_in) rst_in = 1'b0;
		srd(4'h0); chk(r[31:0], 32'h0);
		chk(32'({irq_out, fiq_out}), 32'h3);
		sw(4'h0, 32'h20); sw(4'h8, 32'h100); acc(32'h100); chk(32'(event_out), 32'h0);
		sw(4'h0, 32'h10); srd(4'h0); chk(r[31:0], 32'h10);
		acc(32'h104); chk(32'(event_out), 32'h0);
		acc(32'h100); chk(32'(event_out), 32'h4);
		chk(32'(irq_out), 32'h1);
		cp(1'b0, 4'h2, 32'h0); chk(32'(cp_rdata_out[0]), 32'h1);
		@(negedge clk_sys_in) mem_abort_in = 1'b1;
		@(negedge clk_sys_in) mem_abort_in = 1'b0;
		cp(1'b0, 4'h2, 32'h0); chk(32'(cp_rdata_out[0]), 32'h0);
		cp(1'b0, 4'h7, 32'h0); chk(cp_rdata_out, 32'h0);
		sw(4'h0, 32'h0); acc(32'h100); chk(32'(event_out), 32'h1);
		acc(32'h100); chk(32'(event_out), 32'h0);
		chk(32'({irq_out, fiq_out}), 32'h0);
		pulse_resume(); chk(32'({irq_out, fiq_out}), 32'h3);
		sw(4'hB, 32'h200); sw(4'h0, 32'h10); acc(32'h200, 1'b1); chk(32'(event_out), 32'h0);
		acc(32'h200, 1'b0); chk(32'(event_out), 32'h2);
		chk(32'({irq_out, fiq_out}), 32'h3);
		cp(1'b0, 4'h2, 32'h0); chk(32'(cp_rdata_out[0]), 32'h1);
		sw(4'h5, 32'hA5A5_0F0F); cp(1'b0, 4'h1, 32'h0); chk(cp_rdata_out, 32'h1);
		cp(1'b0, 4'h0, 32'h0); chk(cp_rdata_out, 32'hA5A5_0F0F);
		cp(1'b0, 4'h1, 32'h0); chk(cp_rdata_out, 32'h0);
		cp(1'b1, 4'h1, 32'h1234_5678); srd(4'h4); chk(r[31:0], 32'h2);
		srd(4'h5); chk(r[31:0], 32'h1234_5678);
		srd(4'h4); chk(r[31:0], 32'h0);
		conclude();
	end
endmodule : monitor_mode_debug_control_tb
